/* rtl/pslr_pkg.sv */
// pslr_pkg: constants and types of the strap, indicator and rmii pin block
// assumes byte-addressed 16-bit registers on a plain strobe port
package pslr_pkg;

  // clock and timing
  localparam int CLK_PS = 5000;
  localparam longint BLINK_NS = 64'd40_000_000;
  localparam int BLINK_CYCLES = int'((BLINK_NS * 1000) / CLK_PS);

  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ADV = 4'h4;
  localparam logic [3:0] OFS_LED = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;

  // control register fields
  localparam int CTRL_AN_BIT = 12;
  localparam int CTRL_SPD_BIT = 13;
  localparam logic [15:0] CTRL_RST = 16'h3000;

  // advertisement values for each strap level
  localparam logic [15:0] ADV_HI = 16'h01e1;
  localparam logic [15:0] ADV_LO = 16'h0061;
  localparam logic [15:0] ADV_RST = ADV_HI;

  // station address values
  localparam logic [4:0] ADDR_STRAP_HI = 5'h03;
  localparam logic [4:0] ADDR_STRAP_LO = 5'h00;

  // status register fields
  localparam int STAT_ADDR_LSB = 0;
  localparam int STAT_RUN_BIT = 5;
  localparam int STAT_LINK_BIT = 6;
  localparam int STAT_OVF_BIT = 7;
  localparam int STAT_LED_BIT = 8;

  // indicator modes
  typedef enum logic [1:0] {
    LED_LINK_ACT = 2'h0,
    LED_LINK_ONLY = 2'h1,
    LED_RSVD2 = 2'h2,
    LED_RSVD3 = 2'h3
  } pslr_led_e;
  localparam logic [1:0] LED_MODE_RST = 2'h0;

  // strap sequencing, gray along the path
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_LATCH = 2'b01,
    ST_RUN = 2'b11
  } pslr_state_e;

  typedef struct packed {
    logic an_en;
    logic speed100;
    logic [4:0] station_addr;
  } pslr_cfg_s;

  localparam pslr_cfg_s CFG_RST = '{an_en: 1'b1, speed100: 1'b1, station_addr: 5'h00};

endpackage

/* rtl/pslr_top.sv */
// pslr_top: strap latch, link/activity indicator and rmii dibit framing
// assumes mclk well above the 50 MHz reference; all pins sampled by mclk
//
// Behaviour
// - mode 00 shows link as low and blinks on activity, mode 01 shows link only, 10/11 reserved.
// - each reference clock period with carrier/data-valid high carries one received dibit.
// - each reference clock period with transmit enable high delivers one dibit, captured once; one arriving with both entries full is dropped.
// - the address strap is latched at reset release, high gives 00011b and low gives 00000b.
// - station address bits 4 to 2 are always zero.
// - a high speed strap enables negotiation at 100 Mbps, a low one forces 10 Mbps.
// - the speed strap is loaded into control bits 12 and 13 and into the advertisement.
// - shared strap pins are inputs during reset and drive their function afterwards.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

module pslr_buf2 #(
  parameter int DW = 2
) (
  input wire logic mclk, // clock
  input wire logic reset_n, // sync reset
  input wire logic ce, // clock enable
  input wire logic [DW-1:0] in_data, // fill data
  input wire logic in_valid, // fill valid
  output logic in_ready, // room left
  output logic [DW-1:0] out_data, // head entry
  output logic out_valid, // head valid
  input wire logic out_ready // drain ready
);
  logic [DW-1:0] mem_reg [2];
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_reg[0];

  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_reg <= 2'h0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      in_ready <= (cnt_next != 2'h2);
      out_valid <= (cnt_next != 2'h0);
    end
  end

  // head is always entry 0, so the output is a flop
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (pop) begin
        mem_reg[0] <= (push && cnt_reg == 2'h1) ? in_data : mem_reg[1];
      end else if (push) begin
        mem_reg[cnt_reg[0]] <= in_data;
      end
    end
  end
endmodule

module pslr_top #(
  parameter int BLINK_LEN = pslr_pkg::BLINK_CYCLES
) (
  input wire logic mclk, // 200 MHz clock
  input wire logic reset_n, // chip reset, sync, low active
  input wire logic ce, // clock enable
  input wire logic [pslr_pkg::ADDR_W-1:0] reg_addr, // register byte address
  input wire logic [pslr_pkg::DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [pslr_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after strobe
  input wire logic link_up, // link state from line side
  output pslr_pkg::pslr_cfg_s cfg, // latched configuration
  input wire logic ref_clk_pin, // 50 MHz reference clock pin
  input wire logic tx_en_pin, // mac transmit enable
  input wire logic [1:0] tx_data_pin, // mac transmit dibit
  output logic [1:0] rx_data_pin, // receive dibit to mac
  input wire logic crs_dv_pin_i, // carrier/valid pin level, address strap
  output logic crs_dv_pin_o, // carrier/valid drive value
  output logic crs_dv_pin_oe, // carrier/valid drive enable
  input wire logic link_activity_indicator_i, // indicator pin level, speed strap
  output logic link_activity_indicator_o, // indicator drive value
  output logic link_activity_indicator_oe, // indicator drive enable
  output logic [1:0] tx_dibit, // captured transmit dibit
  output logic tx_valid, // transmit dibit valid
  input wire logic tx_ready, // user takes transmit dibit
  input wire logic [1:0] rx_dibit, // dibit to send to mac
  input wire logic rx_valid, // receive dibit valid
  output logic rx_ready // room for receive dibit
);

  function automatic logic [1:0] reg_sel(input logic [pslr_pkg::ADDR_W-1:0] a);
    logic [1:0] s;
    s = 2'h0;
    case (a)
      pslr_pkg::OFS_CTRL: s = 2'h0;
      pslr_pkg::OFS_ADV: s = 2'h1;
      pslr_pkg::OFS_LED: s = 2'h2;
      pslr_pkg::OFS_STAT: s = 2'h3;
      default: s = 2'h0;
    endcase
    return s;
  endfunction

  function automatic logic reg_hit(input logic [pslr_pkg::ADDR_W-1:0] a);
    return (a == pslr_pkg::OFS_CTRL) || (a == pslr_pkg::OFS_ADV) ||
           (a == pslr_pkg::OFS_LED) || (a == pslr_pkg::OFS_STAT);
  endfunction

  // pin synchronisers, no reset
  logic addr_s1_reg, addr_s2_reg;
  logic spd_s1_reg, spd_s2_reg;
  logic ref_s1_reg, ref_s2_reg, ref_s3_reg;
  logic txen_s1_reg, txen_s2_reg, txen_s3_reg;
  logic [1:0] txd_s1_reg, txd_s2_reg, txd_s3_reg;

  always_ff @(posedge mclk) begin
    if (ce) begin
      addr_s1_reg <= crs_dv_pin_i;
      addr_s2_reg <= addr_s1_reg;
      spd_s1_reg <= link_activity_indicator_i;
      spd_s2_reg <= spd_s1_reg;
    end
  end

  // data gets one stage more than the clock so it is read before the mac moves it
  always_ff @(posedge mclk) begin
    if (ce) begin
      ref_s1_reg <= ref_clk_pin;
      ref_s2_reg <= ref_s1_reg;
      ref_s3_reg <= ref_s2_reg;
      txen_s1_reg <= tx_en_pin;
      txen_s2_reg <= txen_s1_reg;
      txen_s3_reg <= txen_s2_reg;
      txd_s1_reg <= tx_data_pin;
      txd_s2_reg <= txd_s1_reg;
      txd_s3_reg <= txd_s2_reg;
    end
  end

  logic ref_rise;
  assign ref_rise = ref_s2_reg & ~ref_s3_reg;

  pslr_pkg::pslr_state_e state_reg;
  logic running;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= pslr_pkg::ST_SAMPLE;
    end else if (ce) begin
      case (state_reg)
        pslr_pkg::ST_SAMPLE: state_reg <= pslr_pkg::ST_LATCH;
        pslr_pkg::ST_LATCH: state_reg <= pslr_pkg::ST_RUN;
        pslr_pkg::ST_RUN: state_reg <= pslr_pkg::ST_RUN;
        default: state_reg <= pslr_pkg::ST_SAMPLE;
      endcase
    end
  end

  assign running = (state_reg == pslr_pkg::ST_RUN);

  logic [15:0] ctrl_reg;
  logic [15:0] adv_reg;
  logic [1:0] led_mode_reg;
  logic ovf_reg;
  logic wr_ctrl, wr_adv, wr_led, wr_stat;
  logic tx_push_ok, tx_lost;

  assign wr_ctrl = reg_wr && reg_hit(reg_addr) && reg_sel(reg_addr) == 2'h0;
  assign wr_adv = reg_wr && reg_hit(reg_addr) && reg_sel(reg_addr) == 2'h1;
  assign wr_led = reg_wr && reg_hit(reg_addr) && reg_sel(reg_addr) == 2'h2;
  assign wr_stat = reg_wr && reg_hit(reg_addr) && reg_sel(reg_addr) == 2'h3;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cfg <= pslr_pkg::CFG_RST;
    end else if (ce && state_reg == pslr_pkg::ST_SAMPLE) begin
      cfg.station_addr <= addr_s2_reg ? pslr_pkg::ADDR_STRAP_HI
                                      : pslr_pkg::ADDR_STRAP_LO;
      cfg.an_en <= spd_s2_reg;
      cfg.speed100 <= spd_s2_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl_reg <= pslr_pkg::CTRL_RST;
      adv_reg <= pslr_pkg::ADV_RST;
    end else if (ce) begin
      if (state_reg == pslr_pkg::ST_LATCH) begin
        ctrl_reg[pslr_pkg::CTRL_AN_BIT] <= cfg.an_en;
        ctrl_reg[pslr_pkg::CTRL_SPD_BIT] <= cfg.speed100;
        adv_reg <= cfg.speed100 ? pslr_pkg::ADV_HI : pslr_pkg::ADV_LO;
      end else begin
        if (wr_ctrl) begin
          ctrl_reg <= reg_wdata;
        end
        if (wr_adv) begin
          adv_reg <= reg_wdata;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      led_mode_reg <= pslr_pkg::LED_MODE_RST;
    end else if (ce && wr_led) begin
      led_mode_reg <= reg_wdata[1:0];
    end
  end

  // overflow sticky, set wins over write-one-clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ovf_reg <= 1'b0;
    end else if (ce) begin
      if (tx_lost) begin
        ovf_reg <= 1'b1;
      end else if (wr_stat && reg_wdata[pslr_pkg::STAT_OVF_BIT]) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  logic [15:0] stat_word;
  always_comb begin
    stat_word = 16'h0000;
    stat_word[pslr_pkg::STAT_ADDR_LSB +: 5] = cfg.station_addr;
    stat_word[pslr_pkg::STAT_RUN_BIT] = running;
    stat_word[pslr_pkg::STAT_LINK_BIT] = link_up;
    stat_word[pslr_pkg::STAT_OVF_BIT] = ovf_reg;
    stat_word[pslr_pkg::STAT_LED_BIT] = link_activity_indicator_o;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      if (reg_rd && reg_hit(reg_addr)) begin
        case (reg_sel(reg_addr))
          2'h0: reg_rdata <= ctrl_reg;
          2'h1: reg_rdata <= adv_reg;
          2'h2: reg_rdata <= {14'h0000, led_mode_reg};
          2'h3: reg_rdata <= stat_word;
          default: reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // transmit: one dibit per reference period with enable
  logic tx_in_ready;
  assign tx_push_ok = running && ref_rise && txen_s3_reg;
  assign tx_lost = tx_push_ok && !tx_in_ready;

  pslr_buf2 #(.DW(2)) u_tx_buf (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .in_data(txd_s3_reg),
    .in_valid(tx_push_ok),
    .in_ready(tx_in_ready),
    .out_data(tx_dibit),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  // receive: one dibit per reference period with carrier/valid
  logic [1:0] rxb_data;
  logic rxb_valid;
  logic rxb_pop;
  assign rxb_pop = running && ref_rise;

  pslr_buf2 #(.DW(2)) u_rx_buf (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .in_data(rx_dibit),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(rxb_data),
    .out_valid(rxb_valid),
    .out_ready(rxb_pop)
  );

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      crs_dv_pin_o <= 1'b0;
      rx_data_pin <= 2'h0;
    end else if (ce && rxb_pop) begin
      crs_dv_pin_o <= rxb_valid;
      rx_data_pin <= rxb_valid ? rxb_data : 2'h0;
    end
  end

  // shared pins float during reset, drive once running
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      crs_dv_pin_oe <= 1'b0;
      link_activity_indicator_oe <= 1'b0;
    end else if (ce) begin
      crs_dv_pin_oe <= running;
      link_activity_indicator_oe <= running;
    end
  end

  logic [23:0] blink_cnt_reg;
  logic blink_reg;
  logic act_reg;
  logic activity;
  logic blink_tick;

  assign activity = tx_push_ok | (rxb_pop & rxb_valid);
  assign blink_tick = (blink_cnt_reg == 24'(BLINK_LEN - 1));

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      blink_cnt_reg <= 24'h000000;
    end else if (ce) begin
      blink_cnt_reg <= blink_tick ? 24'h000000 : blink_cnt_reg + 24'h000001;
    end
  end

  // activity held until a full off/on blink finishes
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      act_reg <= 1'b0;
      blink_reg <= 1'b0;
    end else if (ce) begin
      if (activity) begin
        act_reg <= 1'b1;
      end else if (blink_tick && blink_reg) begin
        act_reg <= 1'b0;
      end
      if (blink_tick) begin
        blink_reg <= act_reg ? ~blink_reg : 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      link_activity_indicator_o <= 1'b1;
    end else if (ce) begin
      case (pslr_pkg::pslr_led_e'(led_mode_reg))
        pslr_pkg::LED_LINK_ACT: link_activity_indicator_o <= ~link_up | blink_reg;
        pslr_pkg::LED_LINK_ONLY: link_activity_indicator_o <= ~link_up;
        default: link_activity_indicator_o <= 1'b1;
      endcase
    end
  end

endmodule

/* test/pslr_mac_model.sv */
// pslr_mac_model: rmii mac with free running reference clock
// assumes the bench resolves the shared carrier pin
`timescale 1ns/1ps
module pslr_mac_model (
  output logic ref_clk, // reference clock
  output logic tx_en, // transmit enable
  output logic [1:0] tx_data, // transmit dibit
  input wire logic crs_dv, // carrier level, never driven
  input wire logic [1:0] rx_data // receive dibit
);
  logic [1:0] got[$];
  initial begin
    ref_clk = 1'b0;
    tx_en = 1'b0;
    tx_data = 2'h0;
  end
  always #80 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (crs_dv === 1'b1) begin
      got.push_back(rx_data);
    end
  end
  task automatic send(input logic [1:0] d);
    @(posedge ref_clk);
    tx_en <= 1'b1;
    tx_data <= d;
  endtask
  // released data no longer shows the last dibit
  task automatic stop();
    @(posedge ref_clk);
    tx_en <= 1'b0;
    tx_data <= ~tx_data;
  endtask
endmodule

/* test/pslr_top_sva.sv */
// pslr_top_sva: port checks of the strap, indicator and rmii pin block
// assumes binding to pslr_top, single mclk domain
`timescale 1ns/1ps
module pslr_top_sva (
  input wire logic mclk, // clock
  input wire logic reset_n, // sync reset
  input wire logic ce, // clock enable
  input wire logic link_up, // link state
  input wire pslr_pkg::pslr_cfg_s cfg, // config
  input wire logic crs_dv_pin_o, // carrier value
  input wire logic crs_dv_pin_oe, // carrier enable
  input wire logic [1:0] rx_data_pin, // rx dibit
  input wire logic link_activity_indicator_o, // indicator
  input wire logic link_activity_indicator_oe, // indicator enable
  input wire logic [1:0] tx_dibit, // tx head
  input wire logic tx_valid, // tx valid
  input wire logic tx_ready // tx pop
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  AST_ADDR_HI: assert property (cfg.station_addr[4:2] == 3'h0)
    else $error("station address upper bits set");
  AST_RST_PINS: assert property (disable iff (1'b0) !reset_n && ce |=>
    !crs_dv_pin_oe && !link_activity_indicator_oe && cfg == pslr_pkg::CFG_RST)
    else $error("pins driven or config off default in reset");
  AST_OE_RUN: assert property ((reset_n && ce) [*6] |->
    crs_dv_pin_oe && link_activity_indicator_oe) else $error("pins not driven after reset");
  AST_CFG_HOLD: assert property (reset_n [*3] |-> $stable(cfg))
    else $error("config changed after latch");
  AST_NOLINK_OFF: assert property (!link_up [*2] |-> link_activity_indicator_o)
    else $error("indicator lit without link");
  AST_RX_IDLE: assert property (!crs_dv_pin_o |-> rx_data_pin == 2'h0)
    else $error("rx data not idle");
  AST_RX_HOLD: assert property ($rose(crs_dv_pin_o) |=>
    (crs_dv_pin_o && $stable(rx_data_pin)) [*3]) else $error("rx dibit not held");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready && ce |=>
    tx_valid && $stable(tx_dibit)) else $error("tx dibit lost while stalled");
endmodule
bind pslr_top pslr_top_sva i_sva (.mclk, .reset_n, .ce, .link_up, .cfg, .crs_dv_pin_o,
  .crs_dv_pin_oe, .rx_data_pin, .link_activity_indicator_o, .link_activity_indicator_oe,
  .tx_dibit, .tx_valid, .tx_ready);

/* test/pslr_top_tb.sv */
// pslr_top_tb: strap, indicator, register and rmii dibit tests
// assumes pslr_mac_model as far side and the bound checker
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h exp %h", $time, (a), (e)); end end
`define WAIT(c) for (i = 0; i < 400 && !(c); i++) begin @(posedge mclk); #1; end \
  if (i == 400) begin fails++; results(); end
module pslr_top_tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic link_up = 1'b0;
  logic tx_ready = 1'b0;
  logic [1:0] rx_dibit = 2'h0;
  logic rx_valid = 1'b0;
  logic strap_a = 1'b0;
  logic strap_s = 1'b1;
  logic [15:0] reg_rdata, d;
  pslr_pkg::pslr_cfg_s cfg;
  logic ref_clk, tx_en, crs_o, crs_oe, led_o, led_oe, tx_valid, rx_ready;
  logic [1:0] tx_data, rx_data, tx_dibit;
  int fails = 0;
  int n_checks = 0;
  int blinks = 0;
  int i;
  // pull level while the block leaves the pin
  wire crs_w = crs_oe ? crs_o : strap_a;
  wire led_w = led_oe ? led_o : strap_s;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (led_o && link_up) blinks++;
  pslr_top #(.BLINK_LEN(4)) i_dut (.mclk, .reset_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .link_up, .cfg, .ref_clk_pin(ref_clk), .tx_en_pin(tx_en),
    .tx_data_pin(tx_data), .rx_data_pin(rx_data), .crs_dv_pin_i(crs_w), .crs_dv_pin_o(crs_o),
    .crs_dv_pin_oe(crs_oe), .link_activity_indicator_i(led_w),
    .link_activity_indicator_o(led_o), .link_activity_indicator_oe(led_oe), .tx_dibit,
    .tx_valid, .tx_ready, .rx_dibit, .rx_valid, .rx_ready);
  pslr_mac_model i_mac (.ref_clk, .tx_en, .tx_data, .crs_dv(crs_w), .rx_data);
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic results();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    results();
  end
  initial begin
    for (int s = 0; s < 2; s++) begin
      reset_n <= 1'b0;
      strap_a <= ~s[0];
      strap_s <= s[0];
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (8) @(posedge mclk);
      `CHK(cfg, {s[0], s[0], s[0] ? 5'h00 : 5'h03})
      rd(pslr_pkg::OFS_CTRL, d);
      `CHK(d, s[0] ? pslr_pkg::CTRL_RST : 16'h0000)
      rd(pslr_pkg::OFS_ADV, d);
      `CHK(d, s[0] ? pslr_pkg::ADV_HI : pslr_pkg::ADV_LO)
      `CHK({crs_oe, led_oe, led_o}, 3'h7)
    end
    rd(4'h2, d);
    `CHK(d, 16'h0000)
    @(posedge mclk);
    link_up <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(pslr_pkg::OFS_LED, 16'(m));
      repeat (4) @(posedge mclk);
      #1;
      `CHK(led_o, m < 2 ? 1'b0 : 1'b1)
    end
    wr(pslr_pkg::OFS_LED, 16'h0000);
    #1 blinks = 0;
    for (int k = 1; k < 4; k++) i_mac.send(k[1:0]);
    i_mac.stop();
    repeat (8) @(posedge mclk);
    rd(pslr_pkg::OFS_STAT, d);
    `CHK(d[pslr_pkg::STAT_OVF_BIT], 1'b1)
    `CHK(blinks != 0, 1'b1)
    for (int k = 1; k < 3; k++) begin
      `CHK({tx_valid, tx_dibit}, {1'b1, k[1:0]})
      @(posedge mclk);
      tx_ready <= 1'b1;
      @(posedge mclk);
      tx_ready <= 1'b0;
      @(posedge mclk);
      #1;
    end
    `CHK(tx_valid, 1'b0)
    wr(pslr_pkg::OFS_STAT, 16'h0080);
    rd(pslr_pkg::OFS_STAT, d);
    `CHK(d[8:0], 9'h060)
    i_mac.got.delete();
    @(posedge mclk);
    rx_valid <= 1'b1;
    for (int k = 1; k < 4; k++) begin
      rx_dibit <= k[1:0];
      #1;
      `WAIT(rx_ready === 1'b1)
      @(posedge mclk);
    end
    rx_valid <= 1'b0;
    `WAIT(i_mac.got.size() == 3)
    for (int k = 0; k < 3; k++) `CHK(i_mac.got[k], 2'(k + 1))
    repeat (70) @(posedge mclk);
    #1;
    `CHK({crs_o, rx_data, rx_ready, i_mac.got.size() == 3}, 5'h03)
    @(posedge mclk);
    ce <= 1'b0;
    wr(pslr_pkg::OFS_LED, 16'h0003);
    ce <= 1'b1;
    rd(pslr_pkg::OFS_LED, d);
    `CHK(d, 16'h0000)
    results();
  end
endmodule
